// file: rtl/bdm_data_memory.sv
// Banked data memory: address resolution, pointers, bank select and special-function port
`timescale 1ns/10ps
module bdm_data_memory
   import bdm_pkg::*;
(
   // Clock, reset and clock enable
   input  wire  logic                 clk_sys,
   input  wire  logic                 reset,
   input  wire  logic                 ce,
   // Core data-memory request
   input  wire  logic                 mem_req,
   input  wire  bdm_pkg::bdm_op_e     mem_op,
   input  wire  logic [7:0]           mem_addr,
   input  wire  logic [2:0]           mem_bit,
   input  wire  logic [7:0]           mem_wdata,
   // Core read answer
   output logic                       rd_valid,
   output logic [7:0]                 rd_data,
   // Peripheral special-function port
   output logic                       sfr_rd,
   output logic                       sfr_wr,
   output logic [6:0]                 sfr_addr,
   output logic [7:0]                 sfr_wdata,
   output logic [7:0]                 sfr_wmask,
   input  wire  logic [7:0]           sfr_rdata,
   // Register values used elsewhere in the core
   output logic                       bank_select,
   output logic [7:0]                 nvm_control
);

   import bdm_pkg::*;

   bdm_ram_if ram_if ();

   bdm_ram u_ram (
      .clk_sys (clk_sys),
      .reset   (reset),
      .ce      (ce),
      .port    (ram_if.ctrl)
   );

   // Pointers, bank bit and NVM control register held in this block
   logic [7:0] ptr0;
   logic [7:0] bank_capable_pointer;
   logic       bank_select_pointer;
   logic [7:0] nvm_control_reg;

   // Request decode
   logic       take;
   logic       is_write;
   logic       via_ind0;
   logic       via_ind1;
   logic [7:0] eff_addr;
   logic       eff_bank;
   logic       hit_null;
   logic       hit_ram;
   logic       hit_ptr0;
   logic       hit_ptr1;
   logic       hit_bank;
   logic       hit_nvmc;
   logic       hit_ext;
   logic       ext_ro;
   logic [7:0] op_mask;
   logic [7:0] op_data;
   logic [7:0] int_value;
   bdm_src_e   next_src;

   // Answer pipeline
   logic       s1_valid;
   bdm_src_e   s1_src;
   logic [7:0] s1_int;

   assign take     = ce && mem_req;
   assign is_write = (mem_op != BDM_OP_READ);
   assign op_mask  = bdm_op_mask(mem_op, mem_bit);
   assign op_data  = bdm_op_data(mem_op, mem_wdata);

   // Indirect slots redirect through a pointer; every other direct address lands in bank 0
   assign via_ind0 = (mem_addr == ADDR_IND0);
   assign via_ind1 = (mem_addr == ADDR_IND1);

   always_comb begin
      if (via_ind0) begin
         eff_addr = ptr0;
         eff_bank = BANK_ZERO;
      end else if (via_ind1) begin
         eff_addr = bank_capable_pointer;
         eff_bank = bank_select_pointer;
      end else begin
         eff_addr = mem_addr;
         eff_bank = BANK_ZERO;
      end
   end

   // Pointing an indirect slot at either indirect slot (itself or the other) reaches nothing
   assign hit_null = (via_ind0 || via_ind1)
                     && (eff_addr == ADDR_IND0 || eff_addr == ADDR_IND1);

   always_comb begin
      hit_ram  = 1'b0;
      hit_ptr0 = 1'b0;
      hit_ptr1 = 1'b0;
      hit_bank = 1'b0;
      hit_nvmc = 1'b0;
      hit_ext  = 1'b0;
      if (!hit_null) begin
         if (eff_addr >= RAM_FIRST && eff_addr <= RAM_LAST) begin
            hit_ram = (eff_bank == BANK_ZERO);
         end else if (eff_addr <= SFR_LAST) begin
            if (eff_addr == ADDR_NVMC && eff_bank == BANK_ONE) begin
               hit_nvmc = 1'b1;
            end else begin
               // Remaining locations ignore the bank
               hit_ptr0 = (eff_addr == ADDR_PTR0);
               hit_ptr1 = (eff_addr == ADDR_PTR1);
               hit_bank = (eff_addr == ADDR_BANK);
               hit_ext  = !hit_ptr0 && !hit_ptr1 && !hit_bank
                          && SFR_PRESENT_MAP[eff_addr[6:0]];
            end
         end
      end
   end

   assign ext_ro = SFR_READONLY_MAP[eff_addr[6:0]];

   always_comb begin
      int_value = READ_ZERO;
      if (hit_ptr0) begin
         int_value = ptr0;
      end else if (hit_ptr1) begin
         int_value = bank_capable_pointer;
      end else if (hit_bank) begin
         int_value = {7'h00, bank_select_pointer};
      end else if (hit_nvmc) begin
         int_value = nvm_control_reg;
      end
   end

   always_comb begin
      if (hit_ram) begin
         next_src = BDM_SRC_RAM;
      end else if (hit_ptr0 || hit_ptr1 || hit_bank || hit_nvmc) begin
         next_src = BDM_SRC_INT;
      end else if (hit_ext) begin
         next_src = BDM_SRC_EXT;
      end else begin
         next_src = BDM_SRC_NONE;
      end
   end

   // RAM port is driven in the request cycle so its registered read lines up with stage 1
   assign ram_if.we    = take && is_write && hit_ram;
   assign ram_if.addr  = eff_addr[RAM_ADDR_W-1:0];
   assign ram_if.wmask = op_mask;
   assign ram_if.wdata = op_data;

   // Pointer, bank and NVM control registers
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ptr0 <= PTR_RESET;
      end else if (take && is_write && hit_ptr0) begin
         ptr0 <= bdm_merge(ptr0, op_mask, op_data);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         bank_capable_pointer <= PTR_RESET;
      end else if (take && is_write && hit_ptr1) begin
         bank_capable_pointer <= bdm_merge(bank_capable_pointer, op_mask, op_data);
      end
   end

   // Only the bank bit is stored; upper bits read as zero
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         bank_select_pointer <= BANK_RESET;
      end else if (take && is_write && hit_bank && op_mask[BANK_BIT]) begin
         bank_select_pointer <= op_data[BANK_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         nvm_control_reg <= NVMC_RESET;
      end else if (take && is_write && hit_nvmc) begin
         nvm_control_reg <= bdm_merge(nvm_control_reg, op_mask, op_data);
      end
   end

   // Peripheral port: strobes rise one cycle after the request and hold through any edge with ce low
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sfr_rd    <= 1'b0;
         sfr_wr    <= 1'b0;
         sfr_addr  <= 7'h00;
         sfr_wdata <= READ_ZERO;
         sfr_wmask <= MASK_NONE;
      end else if (ce) begin
         sfr_rd    <= take && !is_write && hit_ext;
         sfr_wr    <= take && is_write && hit_ext && !ext_ro;
         sfr_addr  <= eff_addr[6:0];
         sfr_wdata <= op_data;
         sfr_wmask <= op_mask;
      end
   end

   // Stage 1 remembers where the answer comes from
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         s1_valid <= 1'b0;
         s1_src   <= BDM_SRC_NONE;
         s1_int   <= READ_ZERO;
      end else if (ce) begin
         s1_valid <= take && !is_write;
         s1_src   <= next_src;
         s1_int   <= int_value;
      end
   end

   // Stage 2 registers the answer so the core sees a flop output
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rd_valid <= 1'b0;
         rd_data  <= READ_ZERO;
      end else if (ce) begin
         rd_valid <= s1_valid;
         unique case (s1_src)
            BDM_SRC_RAM:  rd_data <= ram_if.rdata;
            BDM_SRC_INT:  rd_data <= s1_int;
            BDM_SRC_EXT:  rd_data <= sfr_rdata;
            BDM_SRC_NONE: rd_data <= READ_ZERO;
         endcase
      end
   end

   assign bank_select = bank_select_pointer;
   assign nvm_control = nvm_control_reg;

endmodule

// file: rtl/bdm_pkg.sv
// Constants, types and helpers shared by the banked data memory
package bdm_pkg;

   localparam int          DATA_W       = 8;
   localparam int          ADDR_W       = 8;
   localparam int          RAM_ADDR_W   = 7;
   localparam int          RAM_DEPTH    = 128;
   localparam int          BIT_SEL_W    = 3;

   // Region boundaries
   localparam logic [7:0]  SFR_FIRST    = 8'h00;
   localparam logic [7:0]  SFR_LAST     = 8'h7f;
   localparam logic [7:0]  RAM_FIRST    = 8'h80;
   localparam logic [7:0]  RAM_LAST     = 8'hff;

   // Special-function locations handled inside this block
   localparam logic [7:0]  ADDR_IND0    = 8'h00;
   localparam logic [7:0]  ADDR_PTR0    = 8'h01;
   localparam logic [7:0]  ADDR_IND1    = 8'h02;
   localparam logic [7:0]  ADDR_PTR1    = 8'h03;
   localparam logic [7:0]  ADDR_BANK    = 8'h04;
   localparam logic [7:0]  ADDR_NVMC    = 8'h40;
   localparam int          BANK_BIT     = 0;
   localparam logic        BANK_ZERO    = 1'b0;
   localparam logic        BANK_ONE     = 1'b1;

   // Values after reset
   localparam logic [7:0]  PTR_RESET    = 8'h00;
   localparam logic        BANK_RESET   = 1'b0;
   localparam logic [7:0]  NVMC_RESET   = 8'h00;
   localparam logic [7:0]  READ_ZERO    = 8'h00;
   localparam logic [7:0]  MASK_ALL     = 8'hff;
   localparam logic [7:0]  MASK_NONE    = 8'h00;

   // One bit per special-function address 00H..7FH
   localparam logic [127:0] SFR_PRESENT_MAP = 128'h0000_0000_0000_007f_fffe_ffff_ffff_fdff;
   localparam logic [127:0] SFR_READONLY_MAP = 128'h0000_0000_0000_0000_0000_0000_0000_0100;

   typedef enum logic [1:0] {
      BDM_OP_READ,
      BDM_OP_WRITE,
      BDM_OP_BSET,
      BDM_OP_BCLR
   } bdm_op_e;

   typedef enum logic [1:0] {
      BDM_SRC_NONE,
      BDM_SRC_RAM,
      BDM_SRC_INT,
      BDM_SRC_EXT
   } bdm_src_e;

   // Bit lanes touched by an operation
   function automatic logic [7:0] bdm_op_mask(input bdm_op_e op, input logic [2:0] sel);
      logic [7:0] one;
      one = 8'h01 << sel;
      return (op == BDM_OP_WRITE) ? MASK_ALL : one;
   endfunction

   // Value placed on the touched lanes
   function automatic logic [7:0] bdm_op_data(input bdm_op_e op, input logic [7:0] wdata);
      unique case (op)
         BDM_OP_BSET:  return MASK_ALL;
         BDM_OP_BCLR:  return MASK_NONE;
         default:      return wdata;
      endcase
   endfunction

   function automatic logic [7:0] bdm_merge(input logic [7:0] old, input logic [7:0] mask,
                                            input logic [7:0] data);
      return (old & ~mask) | (data & mask);
   endfunction

endpackage

// file: rtl/bdm_ram_if.sv
// Carrier between the data memory control and its RAM array
`timescale 1ns/10ps
interface bdm_ram_if;
   logic       we;
   logic [6:0] addr;
   logic [7:0] wmask;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport ctrl (output we, output addr, output wmask, output wdata, input rdata);
   modport mem  (input we, input addr, input wmask, input wdata, output rdata);
endinterface

// file: rtl/bdm_ram.sv
// General-purpose RAM array with per-bit write mask and registered read
`timescale 1ns/10ps
module bdm_ram
   import bdm_pkg::*;
(
   // Clock and control
   input  wire logic   clk_sys,
   input  wire logic   reset,
   input  wire logic   ce,
   // Array port
   bdm_ram_if.mem      port
);

   // Contents are volatile and deliberately not reset
   logic [DATA_W-1:0] mem [RAM_DEPTH];

   always_ff @(posedge clk_sys) begin
      if (ce && port.we) begin
         for (int i = 0; i < DATA_W; i++) begin
            if (port.wmask[i]) begin
               mem[port.addr][i] <= port.wdata[i];
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         port.rdata <= READ_ZERO;
      end else if (ce) begin
         port.rdata <= mem[port.addr];
      end
   end

endmodule

// file: tb/bdm_data_memory_assertions.sv
// Concurrent checks on the banked data memory ports
`timescale 1ns/10ps
module bdm_data_memory_assertions
   import bdm_pkg::*;
(
   // Clock and reset
   input wire logic             clk_sys,
   input wire logic             reset,
   input wire logic             ce,
   // Core port
   input wire logic             mem_req,
   input wire bdm_pkg::bdm_op_e mem_op,
   input wire logic [7:0]       mem_addr,
   input wire logic [2:0]       mem_bit,
   input wire logic [7:0]       mem_wdata,
   input wire logic             rd_valid,
   input wire logic [7:0]       rd_data,
   // Peripheral port and registers
   input wire logic             sfr_rd,
   input wire logic             sfr_wr,
   input wire logic [6:0]       sfr_addr,
   input wire logic [7:0]       sfr_wdata,
   input wire logic [7:0]       sfr_wmask,
   input wire logic             bank_select,
   input wire logic [7:0]       nvm_control
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   logic t;
   logic rq;
   logic prd;
   assign t = ce && mem_req;
   assign rq = t && mem_op == BDM_OP_READ;
   // Peripheral-owned addresses; 00H..04H stay inside the block
   assign prd = SFR_PRESENT_MAP[mem_addr[6:0]] && !mem_addr[7] && mem_addr > 8'h04;

   AST_RD_LAT: assert property (rq ##1 ce |=> rd_valid)
      else $error("read answer missing two cycles after request");
   // rd_valid holds through a frozen edge, so the cause is only two edges back when both were enabled
   AST_RD_CAUSE: assert property (rd_valid && $past(ce) && $past(ce, 2) |-> $past(rq, 2))
      else $error("read answer without a read request");
   AST_SFR_RD: assert property (rq && prd |=> sfr_rd && sfr_addr == $past(mem_addr[6:0]))
      else $error("peripheral read strobe wrong");
   AST_RAM_QUIET: assert property (t && mem_addr[7] |=> !sfr_rd && !sfr_wr)
      else $error("RAM access reached the peripheral port");
   AST_RO_WR: assert property (t && mem_op != BDM_OP_READ && mem_addr == 8'h08 |=> !sfr_wr)
      else $error("write reached a read-only register");
   AST_UNIMPL: assert property (rq && !mem_addr[7] && !SFR_PRESENT_MAP[mem_addr[6:0]] ##1 ce
                                |=> rd_data == 8'h00)
      else $error("unimplemented address read not zero");
   AST_BIT_LANE: assert property (t && mem_op == BDM_OP_BSET && prd && mem_addr != 8'h08
      |=> sfr_wr && sfr_wmask == (8'h01 << $past(mem_bit)) && (sfr_wdata & sfr_wmask) == sfr_wmask)
      else $error("bit set lane wrong");
   AST_BANK: assert property (t && mem_op == BDM_OP_WRITE && mem_addr == 8'h04
                              |=> bank_select == $past(mem_wdata[0]))
      else $error("bank bit not taken from bit 0");
   AST_DIRECT_40: assert property (t && mem_op == BDM_OP_WRITE && mem_addr == 8'h40
                                   |=> $stable(nvm_control))
      else $error("direct write reached bank 1 register");
   AST_FREEZE: assert property (!ce |=> $stable(rd_valid) && $stable(rd_data) && $stable(sfr_rd)
                                && $stable(sfr_wr) && $stable(bank_select) && $stable(nvm_control))
      else $error("state moved while clock enable was low");

   cover property (rq && mem_addr[7]);
   cover property (t && mem_addr == 8'h02 && bank_select);
   cover property (rd_valid ##1 rd_valid);
   cover property (rq ##1 !ce);
endmodule

bind bdm_data_memory bdm_data_memory_assertions u_chk (.clk_sys, .reset, .ce, .mem_req, .mem_op,
   .mem_addr, .mem_bit, .mem_wdata, .rd_valid, .rd_data, .sfr_rd, .sfr_wr, .sfr_addr, .sfr_wdata,
   .sfr_wmask, .bank_select, .nvm_control);

// file: tb/bdm_sfr_model.sv
// Peripheral register bank answering the special-function port
`timescale 1ns/10ps
module bdm_sfr_model (
   // Clock
   input  wire logic       clk_sys,
   // Special-function port
   input  wire logic       sfr_rd,
   input  wire logic       sfr_wr,
   input  wire logic [6:0] sfr_addr,
   input  wire logic [7:0] sfr_wdata,
   input  wire logic [7:0] sfr_wmask,
   output logic      [7:0] sfr_rdata
);
   logic [7:0] regs [128];
   logic [7:0] noise;
   initial begin
      noise = 8'h00;
      for (int i = 0; i < 128; i++) begin
         regs[i] = 8'(i) ^ 8'h5a;
      end
   end
   // Bit operations arrive one-hot, so the peripheral merges lanes itself
   always @(posedge clk_sys) begin
      noise <= noise + 8'h3b;
      if (sfr_wr) begin
         regs[sfr_addr] <= (regs[sfr_addr] & ~sfr_wmask) | (sfr_wdata & sfr_wmask);
      end
   end
   // Outside a read the bus changes every cycle, so a stale answer cannot pass
   assign sfr_rdata = sfr_rd ? regs[sfr_addr] : noise;
endmodule

// file: tb/bdm_data_memory_tb.sv
// Self-checking bench for the banked data memory
`timescale 1ns/10ps
module bdm_data_memory_tb;
   import bdm_pkg::*;
   logic       clk_sys = 1'b0, reset = 1'b1, ce = 1'b1, mem_req = 1'b0;
   bdm_op_e    mem_op = BDM_OP_READ;
   logic [7:0] mem_addr = 8'h00, mem_wdata = 8'h00;
   logic [2:0] mem_bit = 3'h0;
   logic [7:0] rd_data, sfr_wdata, sfr_wmask, sfr_rdata, nvm_control;
   logic       rd_valid, sfr_rd, sfr_wr, bank_select;
   logic [6:0] sfr_addr;
   logic [7:0] ram [128], per [128], p0, p1, nv;
   logic       bk;
   logic [8:0] q [$];
   int         n_fail = 0, total_checks = 0;

   always #12.5 clk_sys = ~clk_sys;

   bdm_data_memory uut (.clk_sys, .reset, .ce, .mem_req, .mem_op, .mem_addr, .mem_bit, .mem_wdata,
      .rd_valid, .rd_data, .sfr_rd, .sfr_wr, .sfr_addr, .sfr_wdata, .sfr_wmask, .sfr_rdata,
      .bank_select, .nvm_control);
   bdm_sfr_model u_per (.clk_sys, .sfr_rd, .sfr_wr, .sfr_addr, .sfr_wdata, .sfr_wmask, .sfr_rdata);

   task automatic chk(string nm, logic [7:0] e, logic [7:0] s);
      total_checks++;
      if (e !== s) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask

   function automatic logic [7:0] rd_at(logic [7:0] a, logic b);
      if (a[7]) return b ? 8'h00 : ram[a[6:0]];
      if (b && a == 8'h40) return nv;
      case (a)
         8'h00, 8'h02: return 8'h00;
         8'h01: return p0;
         8'h03: return p1;
         8'h04: return {7'h00, bk};
         default: return SFR_PRESENT_MAP[a[6:0]] ? per[a[6:0]] : 8'h00;
      endcase
   endfunction

   task automatic wr_at(logic [7:0] t, logic b, logic [7:0] v);
      if (t[7]) begin
         if (!b) ram[t[6:0]] = v;
      end else if (b && t == 8'h40) nv = v;
      else case (t)
         8'h01: p0 = v;
         8'h03: p1 = v;
         8'h04: bk = v[0];
         8'h00, 8'h02, 8'h08: ;
         default: if (SFR_PRESENT_MAP[t[6:0]]) per[t[6:0]] = v;
      endcase
   endtask

   // One cycle: check answers due now, then drive the next request
   task automatic step(logic rq, bdm_op_e op, logic [7:0] a, logic [2:0] bi, logic [7:0] d);
      logic [7:0] t, v, m;
      logic       b;
      @(negedge clk_sys);
      if (q.size() == 2) begin
         chk("rd_valid", {7'h00, q[0][8]}, {7'h00, rd_valid});
         if (q[0][8]) chk("rd_data", q[0][7:0], rd_data);
         void'(q.pop_front());
      end
      chk("bank_select", {7'h00, bk}, {7'h00, bank_select});
      chk("nvm_control", nv, nvm_control);
      mem_req = rq;
      ce = 1'b1;
      mem_op = op;
      mem_addr = a;
      mem_bit = bi;
      mem_wdata = d;
      b = (a == 8'h02) ? bk : 1'b0;
      t = (a == 8'h00) ? p0 : (a == 8'h02) ? p1 : a;
      m = (op == BDM_OP_WRITE) ? 8'hff : 8'h01 << bi;
      v = (op == BDM_OP_BCLR) ? 8'h00 : (op == BDM_OP_BSET) ? 8'hff : d;
      v = (rd_at(t, b) & ~m) | (v & m);
      q.push_back({rq && op == BDM_OP_READ, rd_at(t, b)});
      if (rq && op != BDM_OP_READ) wr_at(t, b, v);
   endtask

   // Clock enable low for one edge: the junk request must change nothing and answers must hold
   task automatic freeze();
      @(negedge clk_sys);
      chk("bank_select", {7'h00, bk}, {7'h00, bank_select});
      chk("nvm_control", nv, nvm_control);
      ce = 1'b0;
      mem_req = 1'b1;
      mem_op = bdm_op_e'($urandom % 4);
      mem_addr = 8'($urandom % 8);
      mem_wdata = 8'($urandom);
   endtask

   task automatic rnd(int n);
      for (int i = 0; i < n; i++) begin
         if ($urandom % 8 == 0) freeze();
         step($urandom % 4 != 0, bdm_op_e'($urandom % 4),
              ($urandom % 2) ? 8'($urandom % 8) : 8'($urandom), 3'($urandom), 8'($urandom));
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      #250000;
      n_fail++;
      wrap_up();
   end

   initial begin
      int s;
      logic [20:0] dir [18] = '{{2'h1, 8'h03, 3'h0, 8'h40}, {2'h1, 8'h04, 3'h0, 8'h01},
         {2'h1, 8'h02, 3'h0, 8'h55}, {2'h0, 8'h02, 3'h0, 8'h00}, {2'h2, 8'h02, 3'h5, 8'h00},
         {2'h1, 8'h03, 3'h0, 8'h85}, {2'h1, 8'h02, 3'h0, 8'hee}, {2'h0, 8'h02, 3'h0, 8'h00},
         {2'h0, 8'h85, 3'h0, 8'h00}, {2'h1, 8'h40, 3'h0, 8'h12}, {2'h1, 8'h08, 3'h0, 8'hff},
         {2'h0, 8'h08, 3'h0, 8'h00}, {2'h0, 8'h09, 3'h0, 8'h00}, {2'h2, 8'h90, 3'h3, 8'h00},
         {2'h3, 8'h90, 3'h0, 8'h00}, {2'h0, 8'h90, 3'h0, 8'h00}, {2'h1, 8'h03, 3'h0, 8'h02},
         {2'h0, 8'h02, 3'h0, 8'h00}};
      s = $urandom(32'hb4693b64);
      for (int i = 0; i < 128; i++) per[i] = 8'(i) ^ 8'h5a;
      {p0, p1, nv, bk} = '0;
      repeat (2) @(negedge clk_sys);
      reset = 1'b0;
      for (int i = 0; i < 128; i++) step(1'b1, BDM_OP_WRITE, 8'h80 | 8'(i), 3'h0, 8'(i * 7));
      foreach (dir[i]) step(1'b1, bdm_op_e'(dir[i][20:19]), dir[i][18:11], dir[i][10:8], dir[i][7:0]);
      rnd(3000);
      repeat (2) step(1'b0, BDM_OP_READ, 8'h00, 3'h0, 8'h00);
      reset = 1'b1;
      {p0, p1, nv, bk} = '0;
      repeat (2) step(1'b0, BDM_OP_READ, 8'h00, 3'h0, 8'h00);
      reset = 1'b0;
      rnd(500);
      repeat (3) step(1'b0, BDM_OP_READ, 8'h00, 3'h0, 8'h00);
      wrap_up();
   end
endmodule
